// *** src/irq_hub_pkg.sv ***
// package: register map, field layout and timing of the audio hub interrupt controller
package irq_hub_pkg;

  // timing
  localparam int unsigned CLK_MHZ        = 125;
  localparam int unsigned FILTER_TIME_NS = 128;
  localparam int unsigned FILTER_CYCLES  = (FILTER_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int          CNT_W          = 5;
  localparam logic [CNT_W-1:0] FILTER_LAST = CNT_W'(FILTER_CYCLES - 1);

  // bus
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;

  // register indices; byte address is four times the index
  localparam logic [11:0] IDX_FIRST_FLAGS  = 12'h730;
  localparam logic [11:0] IDX_SECOND_FLAGS = 12'h731;
  localparam logic [11:0] IDX_LIVE         = 12'h732;
  localparam logic [11:0] IDX_FIRST_MASK   = 12'h738;
  localparam logic [11:0] IDX_SECOND_MASK  = 12'h739;
  localparam logic [11:0] IDX_CTRL         = 12'h740;
  localparam logic [11:0] IDX_FILTER       = 12'h748;

  // implemented bits of each register
  localparam logic [15:0] FIRST_BITS  = 16'h07a1;
  localparam logic [15:0] SECOND_BITS = 16'hdbe3;
  localparam logic [15:0] LIVE_BITS   = 16'hdbe1;

  // edge kind of the second group; the first group is all both-edge
  localparam logic [15:0] SECOND_BOTH = 16'h81e1;
  localparam logic [15:0] SECOND_RISE = 16'h5a02;

  // values after reset
  localparam logic [15:0] FIRST_MASK_RST  = 16'h07a1;
  localparam logic [15:0] SECOND_MASK_RST = 16'hdbe3;
  localparam logic [15:0] CTRL_RST        = 16'h0000;
  localparam logic [15:0] FILTER_RST      = 16'h0021;

  // field positions
  localparam int BIT_GLOBAL_MASK = 0;
  localparam int BIT_WARN        = 15;
  localparam int BIT_SERVO       = 14;
  localparam int BIT_FAULT       = 12;
  localparam int BIT_PORT_TWO    = 11;
  localparam int BIT_PORT_ONE    = 9;
  localparam int BIT_SHUT        = 0;
  localparam int BIT_WARN_FILT   = 5;
  localparam int BIT_SHUT_FILT   = 0;

endpackage

// *** src/stable_filter.sv ***
// stability filter for one slow level, bypassed when disabled
`timescale 1ns/100ps
`default_nettype none

module stable_filter
  import irq_hub_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_en,
  input  wire logic i_level,
  output logic      o_level
);

  typedef struct packed {
    logic             level;
    logic [CNT_W-1:0] count;
  } filter_s;

  filter_s state_r;
  filter_s state_nxt;

  // a change passes only after it has held for the whole window
  always_comb begin
    state_nxt = state_r;
    if (!i_en || (i_level == state_r.level) || (state_r.count == FILTER_LAST)) begin
      state_nxt.level = i_level;
      state_nxt.count = '0;
    end else begin
      state_nxt.count = state_r.count + 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign o_level = state_r.level;

endmodule

`default_nettype wire

// *** src/audio_hub_interrupt_controller.sv ***
// interrupt controller of the audio hub: edge flags, masks, live status, apb slave
//
// Overview of operation
// - live bit 15 shows warning level
// - live bit 0 shows shutdown level
// - live bit 14 shows servo finished
// - live bit 12 shows buffer fault
// - live bits 11, 9 show level detect
// - mask 0 passes, 1 blocks; reset 1
// - second mask bit 12: buffer fault
// - second mask bit 1: microphone detect
// - second mask bits 8..5: lock flags
// - second mask bits 0, 15: overheat
// - second mask bits 11, 9: level detect
// - global mask blocks request; reset 0
// - second mask bit 14: servo finished
// - edges latch flags; write 1 clears
// - request is OR of unmasked flags
// - masked flags still latch and read
// - temperature inputs optionally filtered; enabled
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module audio_hub_interrupt_controller
  import irq_hub_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [ADDR_W-1:0] i_paddr,
  input  wire logic [DATA_W-1:0] i_pwdata,
  output logic      [DATA_W-1:0] o_prdata,
  output logic                   o_pready,
  output logic                   o_pslverr,
  input  wire logic              i_pin_one,
  input  wire logic              i_plug_detect,
  input  wire logic              i_pin_eight,
  input  wire logic              i_pin_nine,
  input  wire logic              i_pin_ten,
  input  wire logic              i_pin_eleven,
  input  wire logic              i_overheat_warning,
  input  wire logic              i_servo_finished,
  input  wire logic              i_core_buffer_fault,
  input  wire logic              i_port_two_level_detect,
  input  wire logic              i_port_one_level_detect,
  input  wire logic              i_rate_conv_two_lock,
  input  wire logic              i_rate_conv_one_lock,
  input  wire logic              i_loop_two_lock,
  input  wire logic              i_loop_one_lock,
  input  wire logic              i_microphone_detect,
  input  wire logic              i_overheat_shutdown,
  output logic                   o_irq
);

  typedef struct packed {
    logic [15:0]       first_meta;
    logic [15:0]       first_sync;
    logic [15:0]       second_meta;
    logic [15:0]       second_sync;
    logic [15:0]       first_prev;
    logic [15:0]       second_prev;
    logic [15:0]       first_flags;
    logic [15:0]       second_flags;
    logic [15:0]       first_source_mask;
    logic [15:0]       second_source_mask;
    logic              global_request_mask;
    logic              overheat_warning_filter_en;
    logic              overheat_shutdown_filter_en;
    logic [DATA_W-1:0] prdata;
    logic              pready;
    logic              pslverr;
    logic              irq;
  } state_s;

  localparam state_s STATE_RST = '{
    first_source_mask:           FIRST_MASK_RST,
    second_source_mask:          SECOND_MASK_RST,
    global_request_mask:         CTRL_RST[BIT_GLOBAL_MASK],
    overheat_warning_filter_en:  FILTER_RST[BIT_WARN_FILT],
    overheat_shutdown_filter_en: FILTER_RST[BIT_SHUT_FILT],
    default:                     '0
  };

  function automatic logic [11:0] word_index(input logic [ADDR_W-1:0] addr);
    word_index = addr[13:2];
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] addr);
    logic [11:0] idx;
    idx = word_index(addr);
    mapped = (addr[15:14] == 2'h0) && (addr[1:0] == 2'h0) &&
             (idx inside {IDX_FIRST_FLAGS, IDX_SECOND_FLAGS, IDX_LIVE,
                          IDX_FIRST_MASK, IDX_SECOND_MASK, IDX_CTRL, IDX_FILTER});
  endfunction

  function automatic logic [15:0] edge_events(input logic [15:0] cur,
                                              input logic [15:0] prev,
                                              input logic [15:0] both,
                                              input logic [15:0] rise);
    edge_events = ((cur ^ prev) & both) | (cur & ~prev & rise);
  endfunction

  state_s      state_r;
  state_s      state_nxt;
  logic [15:0] first_raw;
  logic [15:0] second_raw;
  logic [15:0] first_level;
  logic [15:0] second_level;
  logic [15:0] live;
  logic [15:0] first_events;
  logic [15:0] second_events;
  logic [15:0] first_clear;
  logic [15:0] second_clear;
  logic [15:0] first_kept;
  logic [15:0] second_kept;
  logic [15:0] wdata_low;
  logic [11:0] idx;
  logic        warning_filtered;
  logic        shutdown_filtered;
  logic        overheat_warning_live;
  logic        servo_finished_live;
  logic        core_buffer_fault_live;
  logic        port_two_level_detect_live;
  logic        port_one_level_detect_live;
  logic        overheat_shutdown_live;
  logic        setup;
  logic        access_write;
  logic        pending;

  // sources placed at their flag positions
  assign first_raw = {5'h00, i_pin_eleven, i_pin_ten, i_pin_nine, i_pin_eight,
                      1'b0, i_plug_detect, 4'h0, i_pin_one};
  assign second_raw = {i_overheat_warning, i_servo_finished, 1'b0, i_core_buffer_fault,
                       i_port_two_level_detect, 1'b0, i_port_one_level_detect,
                       i_rate_conv_two_lock, i_rate_conv_one_lock, i_loop_two_lock,
                       i_loop_one_lock, 3'h0, i_microphone_detect, i_overheat_shutdown};

  // filters sit after the synchroniser, before edge detection
  stable_filter u_warning_filter (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_en    (state_r.overheat_warning_filter_en),
    .i_level (state_r.second_sync[BIT_WARN]),
    .o_level (warning_filtered)
  );

  stable_filter u_shutdown_filter (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_en    (state_r.overheat_shutdown_filter_en),
    .i_level (state_r.second_sync[BIT_SHUT]),
    .o_level (shutdown_filtered)
  );

  assign first_level  = state_r.first_sync;
  assign second_level = {warning_filtered, state_r.second_sync[14:1], shutdown_filtered};

  assign overheat_warning_live      = second_level[BIT_WARN];
  assign servo_finished_live        = second_level[BIT_SERVO];
  assign core_buffer_fault_live     = second_level[BIT_FAULT];
  assign port_two_level_detect_live = second_level[BIT_PORT_TWO];
  assign port_one_level_detect_live = second_level[BIT_PORT_ONE];
  assign overheat_shutdown_live     = second_level[BIT_SHUT];

  assign live = {overheat_warning_live, servo_finished_live, 1'b0, core_buffer_fault_live,
                 port_two_level_detect_live, 1'b0, port_one_level_detect_live,
                 second_level[8:5], 4'h0, overheat_shutdown_live} & LIVE_BITS;

  assign first_events  = edge_events(first_level, state_r.first_prev, FIRST_BITS, 16'h0000);
  assign second_events = edge_events(second_level, state_r.second_prev, SECOND_BOTH, SECOND_RISE);

  assign setup        = i_psel & ~i_penable;
  assign access_write = i_psel & i_penable & i_pwrite & state_r.pready & ~state_r.pslverr;
  assign idx          = word_index(i_paddr);
  assign wdata_low    = i_pwdata[15:0];

  assign first_clear  = (access_write && idx == IDX_FIRST_FLAGS) ? wdata_low & FIRST_BITS : '0;
  assign second_clear = (access_write && idx == IDX_SECOND_FLAGS) ? wdata_low & SECOND_BITS : '0;
  assign first_kept   = state_r.first_flags & ~first_clear;
  assign second_kept  = state_r.second_flags & ~second_clear;

  // any unmasked flag raises the request
  assign pending = |(state_r.first_flags & ~state_r.first_source_mask) |
                   |(state_r.second_flags & ~state_r.second_source_mask);

  always_comb begin
    logic [15:0] rd;
    rd = '0;
    state_nxt = state_r;
    // first stage feeds only the second stage
    state_nxt.first_meta  = first_raw;
    state_nxt.first_sync  = state_r.first_meta;
    state_nxt.second_meta = second_raw;
    state_nxt.second_sync = state_r.second_meta;
    state_nxt.first_prev  = first_level;
    state_nxt.second_prev = second_level;
    // flags latch whatever the mask; set beats clear
    state_nxt.first_flags  = first_kept | first_events;
    state_nxt.second_flags = second_kept | second_events;
    if (access_write) begin
      case (idx)
        IDX_FIRST_MASK: begin
          state_nxt.first_source_mask = wdata_low & FIRST_BITS;
        end
        IDX_SECOND_MASK: begin
          state_nxt.second_source_mask = wdata_low & SECOND_BITS;
        end
        IDX_CTRL: begin
          state_nxt.global_request_mask = wdata_low[BIT_GLOBAL_MASK];
        end
        IDX_FILTER: begin
          state_nxt.overheat_warning_filter_en  = wdata_low[BIT_WARN_FILT];
          state_nxt.overheat_shutdown_filter_en = wdata_low[BIT_SHUT_FILT];
        end
        default: begin
          state_nxt.irq = state_r.irq;
        end
      endcase
    end
    case (idx)
      IDX_FIRST_FLAGS:  rd = state_r.first_flags;
      IDX_SECOND_FLAGS: rd = state_r.second_flags;
      IDX_LIVE:         rd = live;
      IDX_FIRST_MASK:   rd = state_r.first_source_mask;
      IDX_SECOND_MASK:  rd = state_r.second_source_mask;
      IDX_CTRL:         rd = {15'h0000, state_r.global_request_mask};
      IDX_FILTER:       rd = {10'h000, state_r.overheat_warning_filter_en, 4'h0,
                              state_r.overheat_shutdown_filter_en};
      default:          rd = '0;
    endcase
    // zero wait: answer is ready in the access cycle
    state_nxt.pready  = setup;
    state_nxt.pslverr = setup & ~mapped(i_paddr);
    // refused reads return zero, not whatever the index aliases to
    state_nxt.prdata  = (setup && !i_pwrite && mapped(i_paddr)) ? {16'h0000, rd} : '0;
    state_nxt.irq = ~state_r.global_request_mask & pending;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= STATE_RST;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign o_prdata  = state_r.prdata;
  assign o_pready  = state_r.pready;
  assign o_pslverr = state_r.pslverr;
  assign o_irq     = state_r.irq;

  default clocking cb @(posedge i_clk);
  endclocking

  default disable iff (!i_rst_n);

  sequence s_setup_live_read;
    setup && !i_pwrite && mapped(i_paddr) && idx == IDX_LIVE;
  endsequence

  sequence s_ready_pulse;
    o_pready ##1 !o_pready;
  endsequence

  chk_live_read: assert property (
    s_setup_live_read |=> o_prdata == {16'h0000, $past(live)})
    else $error("live status read does not match input levels");

  chk_ready_pulse: assert property (
    setup |=> s_ready_pulse)
    else $error("ready not a single cycle after setup");

  chk_unmapped_err: assert property (
    setup && !mapped(i_paddr) |=> o_pslverr && o_pready)
    else $error("unmapped access not answered with error");

  chk_upper_zero: assert property (
    o_pready |-> o_prdata[31:16] == 16'h0000)
    else $error("upper read data bits not zero");

  chk_flag_set_first: assert property (
    first_events != 16'h0000 |=>
      (state_r.first_flags & $past(first_events)) == $past(first_events))
    else $error("first group edge did not latch a flag");

  chk_flag_set_second: assert property (
    second_events != 16'h0000 |=>
      (state_r.second_flags & $past(second_events)) == $past(second_events))
    else $error("second group edge did not latch a flag");

  chk_flag_hold: assert property (
    second_kept != 16'h0000 |=>
      (state_r.second_flags & $past(second_kept)) == $past(second_kept))
    else $error("flag dropped without a clearing write");

  chk_mask_write: assert property (
    access_write && idx == IDX_SECOND_MASK |=>
      state_r.second_source_mask == ($past(wdata_low) & SECOND_BITS))
    else $error("second mask write not stored");

  chk_irq_raise: assert property (
    pending && !state_r.global_request_mask |=> o_irq)
    else $error("request missing for unmasked flag");

  chk_irq_release: assert property (
    !pending |=> !o_irq)
    else $error("request stays with no unmasked flag");

  chk_global_block: assert property (
    state_r.global_request_mask |=> !o_irq)
    else $error("request raised while globally masked");

  chk_filter_bypass: assert property (
    !state_r.overheat_warning_filter_en |=>
      warning_filtered == $past(state_r.second_sync[BIT_WARN]))
    else $error("disabled filter does not follow input");

  chk_filter_stable: assert property (
    $past(state_r.overheat_shutdown_filter_en) && $changed(shutdown_filtered) |->
      $past(state_r.second_sync[BIT_SHUT]) == shutdown_filtered &&
      $past(state_r.second_sync[BIT_SHUT], 2) == shutdown_filtered &&
      $past(state_r.second_sync[BIT_SHUT], 3) == shutdown_filtered)
    else $error("filter passed a short pulse");

endmodule

`default_nettype wire

// *** sim/irq_host_model.sv ***
// host side of the request line: counts each new request it sees
`timescale 1ns/100ps
`default_nettype none

module irq_host_model (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_irq,
  output var  int   o_seen
);
  logic irq_r;

  // level request, so only a rise means new work
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_r  <= 1'b0;
      o_seen <= 0;
    end else begin
      irq_r <= i_irq;
      if (i_irq && !irq_r)
        o_seen <= o_seen + 1;
    end
  end
endmodule

`default_nettype wire

// *** sim/tb_top.sv ***
// bench: register access, source edges, masks, filter and reset of the interrupt hub
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  import irq_hub_pkg::*;
  localparam logic [15:0] A_F1 = 16'h1cc0, A_F2 = 16'h1cc4, A_LIVE = 16'h1cc8, A_M1 = 16'h1ce0;
  localparam logic [15:0] A_M2 = 16'h1ce4, A_CTRL = 16'h1d00, A_FILT = 16'h1d20;
  typedef struct { logic grp; int b; logic both; } row_s;
  row_s        rows [17] = '{'{0, 0, 1}, '{0, 5, 1}, '{0, 7, 1}, '{0, 8, 1}, '{0, 9, 1}, '{0, 10, 1},
                             '{1, 15, 1}, '{1, 14, 0}, '{1, 12, 0}, '{1, 11, 0}, '{1, 9, 0}, '{1, 8, 1},
                             '{1, 7, 1}, '{1, 6, 1}, '{1, 5, 1}, '{1, 1, 0}, '{1, 0, 1}};
  logic [15:0] rs_a [9] = '{A_F1, A_F2, A_LIVE, A_M1, A_M2, A_CTRL, A_FILT, 16'h1d04, 16'h1cc2};
  logic [15:0] rs_v [9] = '{16'h0, 16'h0, 16'h0, 16'h07a1, 16'hdbe3, 16'h0, 16'h0021, 16'h0, 16'h0};
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [15:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic [16:0] s = '0;
  logic [31:0] q;
  logic        e;
  logic [15:0] m, fa, ma, mr;
  int          n_fail = 0;
  int          checks = 0;
  int          seen;

  always #4 clk = ~clk;

  audio_hub_interrupt_controller u_audio_hub_interrupt_controller (
    .i_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_pin_one(s[0]), .i_plug_detect(s[1]), .i_pin_eight(s[2]), .i_pin_nine(s[3]), .i_pin_ten(s[4]),
    .i_pin_eleven(s[5]), .i_overheat_warning(s[6]), .i_servo_finished(s[7]), .i_core_buffer_fault(s[8]),
    .i_port_two_level_detect(s[9]), .i_port_one_level_detect(s[10]), .i_rate_conv_two_lock(s[11]),
    .i_rate_conv_one_lock(s[12]), .i_loop_two_lock(s[13]), .i_loop_one_lock(s[14]),
    .i_microphone_detect(s[15]), .i_overheat_shutdown(s[16]), .o_irq(irq));

  irq_host_model u_irq_host_model (.i_clk(clk), .i_rst_n(rst_n), .i_irq(irq), .o_seen(seen));

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp, input string what);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s got %b want %b", $time, what, got, exp);
    end
  endtask

  // request held until pready is seen high; one idle cycle between transfers
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // ends when pready is seen high; the watchdog ends it if pready never comes
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    cmp_bit(pready, 1'b1, "ready");
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] exp, input logic eexp);
    apb(1'b0, a, 32'h0);
    cmp_word(q, exp, "read data");
    cmp_bit(e, eexp, "slave error");
  endtask

  task automatic print_verdict;
    if (n_fail == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    wait_cyc(3);
    rst_n <= 1'b1;
    wait_cyc(2);
    // one source at a time, only its own mask open
    for (int i = 0; i < 17; i++) begin
      m  = 16'h1 << rows[i].b;
      fa = rows[i].grp ? A_F2 : A_F1;
      ma = rows[i].grp ? A_M2 : A_M1;
      mr = rows[i].grp ? 16'hdbe3 : 16'h07a1;
      wr(ma, {16'h0, mr & ~m});
      s[i] <= 1'b1;
      wait_cyc(30);
      rd(fa, {16'h0, m}, 1'b0);
      cmp_bit(irq, 1'b1, "request raised");
      rd(A_LIVE, rows[i].grp ? {16'h0, LIVE_BITS & m} : 32'h0, 1'b0);
      wr(fa, {16'h0, m});
      wait_cyc(2);
      cmp_bit(irq, 1'b0, "request dropped");
      s[i] <= 1'b0;
      wait_cyc(30);
      rd(fa, rows[i].both ? {16'h0, m} : 32'h0, 1'b0);
      wr(fa, {16'h0, m});
      wr(ma, {16'h0, mr});
    end
    cmp_word(32'(seen), 32'd29, "host request count");
    s[7] <= 1'b1;
    wait_cyc(30);
    rd(A_F2, 32'h4000, 1'b0);
    cmp_bit(irq, 1'b0, "masked source");
    wr(A_LIVE, 32'hffff);
    rd(A_LIVE, 32'h4000, 1'b0);
    wr(A_M2, 32'hffffbfff);
    rd(A_M2, 32'h9be3, 1'b0);
    cmp_bit(irq, 1'b1, "unmasked later");
    wr(A_CTRL, 32'hffffffff);
    wait_cyc(2);
    cmp_bit(irq, 1'b0, "global mask");
    rd(A_CTRL, 32'h1, 1'b0);
    wr(A_CTRL, 32'h0);
    wait_cyc(2);
    cmp_bit(irq, 1'b1, "global unmask");
    wr(A_F2, 32'h4000);
    wr(A_M2, 32'hdbe3);
    s[7] <= 1'b0;
    // short glitch on shutdown input, filter on then off
    s[16] <= 1'b1;
    wait_cyc(8);
    s[16] <= 1'b0;
    wait_cyc(40);
    rd(A_F2, 32'h0, 1'b0);
    wr(A_FILT, 32'h0);
    s[16] <= 1'b1;
    wait_cyc(8);
    s[16] <= 1'b0;
    wait_cyc(10);
    rd(A_F2, 32'h1, 1'b0);
    wr(A_F2, 32'h1);
    wr(A_FILT, 32'h21);
    // two flags pending: request holds until both are gone
    wr(A_M1, 32'h0780);
    s[1:0] <= 2'b11;
    wait_cyc(30);
    rd(16'h1cc2, 32'h0, 1'b1);
    wr(A_F1, 32'h1);
    wait_cyc(2);
    cmp_bit(irq, 1'b1, "one flag left");
    wr(A_F1, 32'h20);
    wait_cyc(2);
    cmp_bit(irq, 1'b0, "all cleared");
    s[1:0] <= 2'b00;
    wait_cyc(30);
    cmp_bit(irq, 1'b1, "falling edges");
    // reset mid-run with flags set and masks open
    rst_n <= 1'b0;
    wait_cyc(3);
    cmp_bit(irq, 1'b0, "request in reset");
    rst_n <= 1'b1;
    wait_cyc(2);
    for (int i = 0; i < 9; i++)
      rd(rs_a[i], {16'h0, rs_v[i]}, i >= 7);
    print_verdict();
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    print_verdict();
  end
endmodule

`default_nettype wire
